// ### hw/audio_dma_timer_cfg.svh
// Constants for the audio DMA and timer counter block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef AUDIO_DMA_TIMER_CFG_SVH
`define AUDIO_DMA_TIMER_CFG_SVH

// Register indices; the byte address is four times the index.
`define REG_LATCH 6'h00
`define REG_PLAY_BASE 6'h08
`define REG_PLAY_CUR 6'h09
`define REG_CAP_BASE 6'h0a
`define REG_CAP_CUR 6'h0b
`define REG_TIMER_BASE 6'h0c
`define REG_TIMER_CUR 6'h0d
`define REG_CTRL 6'h10
`define REG_STATUS 6'h11
`define REG_MASK 6'h12

// Control register bits; status and mask share the channel numbering.
`define CTRL_PLAY_EN 0
`define CTRL_CAP_EN 1
`define CTRL_TIMER_EN 2
`define CTRL_TB_SEL 3
`define CTRL_W 4
`define CH_PLAY 0
`define CH_CAP 1
`define CH_TIMER 2
`define NUM_CH 3
`define NUM_DMA_CH 2

// Reset and step values.
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define LAST_BYTE 2'h3
`define BYTE_ZERO 2'h0
`define BYTE_ONE 2'h1

// Timing.
`define CLK_PERIOD_NS 50
`define TB_SHORT_NS 10000
`define TB_LONG_NS 100000000
`define TB_SHORT_CYCLES (`TB_SHORT_NS / `CLK_PERIOD_NS)
`define TB_LONG_CYCLES (`TB_LONG_NS / `CLK_PERIOD_NS)
`define TB_CNT_W 21

`endif

// ### hw/audio_dma_timer_pkg.sv
// Types shared by the audio DMA and timer counter block.
// Assumes no other package.
package audio_dma_timer_pkg;
    typedef logic [15:0] count_t;
    typedef logic [5:0] reg_index_t;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_e;
endpackage

// ### hw/count_if.sv
// Connection between the register front end and one down-counter pair.
// Assumes the front end drives steering and the counter returns its state.
`timescale 1ns/100ps
`default_nettype none
interface count_if;
    logic en;
    logic tick;
    logic base_wr;
    logic cur_wr;
    audio_dma_timer_pkg::count_t wdata;
    audio_dma_timer_pkg::count_t base;
    audio_dma_timer_pkg::count_t cur;
    logic wrap;
    modport ctrl (output en, output tick, output base_wr, output cur_wr, output wdata,
        input base, input cur, input wrap);
    modport chan (input en, input tick, input base_wr, input cur_wr, input wdata,
        output base, output cur, output wrap);
endinterface
`default_nettype wire

// ### hw/count_channel.sv
// One base and current down-counter pair with automatic reload.
// Assumes tick is a one-cycle pulse and writes come only while disabled.
`include "audio_dma_timer_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module count_channel (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Front end
    count_if.chan bus
);
    audio_dma_timer_pkg::count_t base_reg;
    audio_dma_timer_pkg::count_t base_next;
    audio_dma_timer_pkg::count_t cur_reg;
    audio_dma_timer_pkg::count_t cur_next;
    logic step;

    assign step = bus.en & bus.tick;
    assign bus.wrap = step & (cur_reg == `COUNT_ZERO);
    assign bus.base = base_reg;
    assign bus.cur = cur_reg;

    always_comb begin
        base_next = base_reg;
        cur_next = cur_reg;
        if (bus.base_wr) begin
            base_next = bus.wdata;
            cur_next = bus.wdata;
        end else if (bus.cur_wr) begin
            cur_next = bus.wdata;
        end else if (step) begin
            if (cur_reg == `COUNT_ZERO) begin
                cur_next = base_reg;
            end else begin
                cur_next = cur_reg - `COUNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            base_reg <= `COUNT_ZERO;
            cur_reg <= `COUNT_ZERO;
        end else begin
            base_reg <= base_next;
            cur_reg <= cur_next;
        end
    end
endmodule
`default_nettype wire

// ### hw/time_base_gen.sv
// Timer period generator giving one tick per selected time base.
// Assumes the enable restarts the period when it goes low.
`include "audio_dma_timer_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module time_base_gen #(
    parameter int unsigned LONG_CYCLES = `TB_LONG_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Control
    input wire logic en_in,
    input wire logic sel_in,
    // Period tick
    output logic tick_out
);
    localparam logic [`TB_CNT_W-1:0] SHORT_LAST = `TB_CNT_W'(`TB_SHORT_CYCLES - 1);
    localparam logic [`TB_CNT_W-1:0] LONG_LAST = `TB_CNT_W'(LONG_CYCLES - 1);
    localparam logic [`TB_CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [`TB_CNT_W-1:0] CNT_ONE = `TB_CNT_W'(1);

    logic [`TB_CNT_W-1:0] cnt_reg;
    logic [`TB_CNT_W-1:0] cnt_next;
    logic [`TB_CNT_W-1:0] last;

    assign last = sel_in ? LONG_LAST : SHORT_LAST;
    assign tick_out = en_in & (cnt_reg >= last);

    always_comb begin
        if (!en_in || tick_out) begin
            cnt_next = CNT_ZERO;
        end else begin
            cnt_next = cnt_reg + CNT_ONE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_reg <= CNT_ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// ### hw/audio_dma_timer.sv
// Playback, capture and timer down-counters behind an Avalon-MM slave.
// Assumes word addressing, one-cycle byte pulses from the system DMA and synchronous inputs.
// Every request takes one wait state and then commits at acceptance.
//
// Chosen here: the Avalon-MM slave port.
`include "audio_dma_timer_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module audio_dma_timer #(
    parameter int unsigned TB_LONG_CYCLES = `TB_LONG_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Avalon-MM slave
    input wire logic [5:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [3:0] byteenable_in,
    input wire logic [31:0] writedata_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    // DMA byte strobes
    input wire logic play_byte_in,
    input wire logic cap_byte_in,
    // Interrupt
    output logic irq_out
);
    audio_dma_timer_pkg::bus_state_e state_reg;
    audio_dma_timer_pkg::bus_state_e state_next;
    audio_dma_timer_pkg::word_t readdata_reg;
    audio_dma_timer_pkg::word_t readdata_next;
    logic [7:0] latch_reg;
    logic [7:0] latch_next;
    logic [`CTRL_W-1:0] ctrl_reg;
    logic [`CTRL_W-1:0] ctrl_next;
    logic [`NUM_CH-1:0] status_reg;
    logic [`NUM_CH-1:0] status_next;
    logic [`NUM_CH-1:0] mask_reg;
    logic [`NUM_CH-1:0] mask_next;

    logic accept;
    logic wr_accept;
    logic rd_accept;
    logic low_lane;
    logic high_lane;
    logic commit;
    audio_dma_timer_pkg::count_t commit_val;
    logic timer_tick;
    logic [`NUM_CH-1:0] tick_vec;
    logic [`NUM_CH-1:0] wrap_vec;
    audio_dma_timer_pkg::count_t base_arr [`NUM_CH];
    audio_dma_timer_pkg::count_t cur_arr [`NUM_CH];
    logic [`NUM_DMA_CH-1:0] byte_strobe;
    logic any_req;
    logic rd_wait;
    logic wr_low;
    logic hit_latch;
    logic hit_ctrl;
    logic hit_status;
    logic hit_mask;
    logic timer_en;
    logic timer_sel;
    logic [`NUM_CH-1:0] pending;
    logic [`NUM_CH-1:0] clr_vec;

    count_if ch_if [`NUM_CH] ();

    // Bus handshake: each request waits one cycle, then is accepted.
    assign any_req = read_in | write_in;
    assign accept = (state_reg == audio_dma_timer_pkg::BUS_ACK);
    assign wr_accept = accept & write_in;
    assign rd_accept = accept & read_in;
    assign waitrequest_out = any_req & ~accept;
    assign rd_wait = read_in & ~accept;
    assign readdata_out = readdata_reg;

    // Address decode for the single-register locations.
    assign wr_low = wr_accept & low_lane;
    assign hit_latch = (address_in == `REG_LATCH);
    assign hit_ctrl = (address_in == `REG_CTRL);
    assign hit_status = (address_in == `REG_STATUS);
    assign hit_mask = (address_in == `REG_MASK);

    always_comb begin
        case (state_reg)
            audio_dma_timer_pkg::BUS_IDLE: begin
                if (any_req) begin
                    state_next = audio_dma_timer_pkg::BUS_ACK;
                end else begin
                    state_next = audio_dma_timer_pkg::BUS_IDLE;
                end
            end
            audio_dma_timer_pkg::BUS_ACK: begin
                state_next = audio_dma_timer_pkg::BUS_IDLE;
            end
            default: begin
                state_next = audio_dma_timer_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_reg <= audio_dma_timer_pkg::BUS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // A low-lane-only write fills the holding latch; a high-lane write commits.
    assign low_lane = byteenable_in[0];
    assign high_lane = byteenable_in[1];
    assign commit = wr_accept & high_lane;
    always_comb begin
        if (low_lane) begin
            commit_val = writedata_in[15:0];
        end else begin
            commit_val = {writedata_in[15:8], latch_reg};
        end
    end

    always_comb begin
        latch_next = latch_reg;
        if (wr_low && !high_lane) begin
            latch_next = writedata_in[7:0];
        end else if (wr_low && hit_latch) begin
            latch_next = writedata_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            latch_reg <= 8'h00;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // Control register.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_low && hit_ctrl) begin
            ctrl_next = writedata_in[`CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Interrupt mask register.
    always_comb begin
        mask_next = mask_reg;
        if (wr_low && hit_mask) begin
            mask_next = writedata_in[`NUM_CH-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            mask_reg <= '0;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // Sticky status; a read clears only the bits it returned, and a new wrap wins.
    assign clr_vec = readdata_reg[`NUM_CH-1:0];
    always_comb begin
        status_next = status_reg;
        if (rd_accept && hit_status) begin
            status_next = status_reg & ~clr_vec;
        end
        status_next = status_next | wrap_vec;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    assign pending = status_reg & mask_reg;
    assign irq_out = |pending;

    // Read data is captured while the request waits, so it stands at acceptance.
    always_comb begin
        readdata_next = readdata_reg;
        if (rd_wait) begin
            case (address_in)
                `REG_LATCH: begin
                    readdata_next = {24'h00_0000, latch_reg};
                end
                `REG_PLAY_BASE: begin
                    readdata_next = {16'h0000, base_arr[`CH_PLAY]};
                end
                `REG_PLAY_CUR: begin
                    readdata_next = {16'h0000, cur_arr[`CH_PLAY]};
                end
                `REG_CAP_BASE: begin
                    readdata_next = {16'h0000, base_arr[`CH_CAP]};
                end
                `REG_CAP_CUR: begin
                    readdata_next = {16'h0000, cur_arr[`CH_CAP]};
                end
                `REG_TIMER_BASE: begin
                    readdata_next = {16'h0000, base_arr[`CH_TIMER]};
                end
                `REG_TIMER_CUR: begin
                    readdata_next = {16'h0000, cur_arr[`CH_TIMER]};
                end
                `REG_CTRL: begin
                    readdata_next = {28'h000_0000, ctrl_reg};
                end
                `REG_STATUS: begin
                    readdata_next = {29'h0000_0000, status_reg};
                end
                `REG_MASK: begin
                    readdata_next = {29'h0000_0000, mask_reg};
                end
                default: begin
                    readdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            readdata_reg <= 32'h0000_0000;
        end else begin
            readdata_reg <= readdata_next;
        end
    end

    // Byte-to-count prescalers for the two DMA channels.
    assign byte_strobe[`CH_PLAY] = play_byte_in;
    assign byte_strobe[`CH_CAP] = cap_byte_in;

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_DMA_CH; gi = gi + 1) begin : g_bytes
            logic [1:0] byte_cnt_reg;
            logic [1:0] byte_cnt_next;
            always_comb begin
                byte_cnt_next = byte_cnt_reg;
                if (!ctrl_reg[gi]) begin
                    byte_cnt_next = `BYTE_ZERO;
                end else if (byte_strobe[gi]) begin
                    byte_cnt_next = byte_cnt_reg + `BYTE_ONE;
                end
            end
            always_ff @(posedge clk_in) begin
                if (!rst_b_in) begin
                    byte_cnt_reg <= `BYTE_ZERO;
                end else begin
                    byte_cnt_reg <= byte_cnt_next;
                end
            end
            assign tick_vec[gi] = byte_strobe[gi] & (byte_cnt_reg == `LAST_BYTE);
        end
    endgenerate

    assign timer_en = ctrl_reg[`CTRL_TIMER_EN];
    assign timer_sel = ctrl_reg[`CTRL_TB_SEL];
    time_base_gen #(
        .LONG_CYCLES(TB_LONG_CYCLES)
    ) u_time_base (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(timer_en),
        .sel_in(timer_sel),
        .tick_out(timer_tick)
    );
    assign tick_vec[`CH_TIMER] = timer_tick;

    // Counter pairs; base sits at an even index and current right after it.
    generate
        for (gi = 0; gi < `NUM_CH; gi = gi + 1) begin : g_chan
            localparam logic [5:0] BASE_A = 6'(`REG_PLAY_BASE + 2 * gi);
            localparam logic [5:0] CUR_A = 6'(`REG_PLAY_BASE + 2 * gi + 1);
            logic base_hit;
            logic cur_hit;
            assign base_hit = (address_in == BASE_A);
            assign cur_hit = (address_in == CUR_A);
            assign ch_if[gi].en = ctrl_reg[gi];
            assign ch_if[gi].tick = tick_vec[gi];
            assign ch_if[gi].base_wr = commit & base_hit;
            assign ch_if[gi].cur_wr = commit & cur_hit;
            assign ch_if[gi].wdata = commit_val;
            assign base_arr[gi] = ch_if[gi].base;
            assign cur_arr[gi] = ch_if[gi].cur;
            assign wrap_vec[gi] = ch_if[gi].wrap;
            count_channel u_chan (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .bus(ch_if[gi].chan)
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ### dv/audio_dma_timer_sva.sv
// Concurrent checks on the ports of the audio DMA and timer counter block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module audio_dma_timer_chk (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Register bus
    input wire logic [5:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [3:0] byteenable_in,
    input wire logic [31:0] writedata_in,
    input wire logic [31:0] readdata_out,
    input wire logic waitrequest_out,
    // Strobes and interrupt
    input wire logic play_byte_in,
    input wire logic cap_byte_in,
    input wire logic irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic touched_reg;
    logic touched_next;
    wire logic rd_acc = read_in && !waitrequest_out;
    wire logic wr_acc = write_in && !waitrequest_out;
    always_comb begin
        touched_next = touched_reg || wr_acc;
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            touched_reg <= 1'b0;
        end else begin
            touched_reg <= touched_next;
        end
    end
    sequence s_req_open;
        $rose(read_in || write_in);
    endsequence
    sequence s_wait_once;
        waitrequest_out ##1 !waitrequest_out;
    endsequence
    property p_copy(logic [5:0] a_base, logic [5:0] a_cur, logic strobe);
        rd_acc && address_in == a_cur && !$past(strobe, 2) && !$past(strobe, 3) &&
            $past(wr_acc && address_in == a_base && byteenable_in == 4'h3, 3)
            |-> readdata_out[15:0] == $past(writedata_in[15:0], 3);
    endproperty
    chk_wait_first: assert property (s_req_open |-> s_wait_once)
        else $error("request not answered after one wait");
    chk_idle_nowait: assert property (!(read_in || write_in) |-> !waitrequest_out)
        else $error("wait raised while idle");
    chk_data_stands: assert property (!read_in |=> $stable(readdata_out))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (rd_acc && address_in == 6'h01 |-> readdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_latch_width: assert property (rd_acc && address_in == 6'h00 |-> readdata_out[31:8] == 24'h0)
        else $error("latch read wider than a byte");
    chk_reset_counts: assert property (rd_acc && !touched_reg && address_in >= 6'h08 &&
        address_in <= 6'h0d |-> readdata_out == 32'h0)
        else $error("count not zero after reset");
    chk_irq_reset: assert property ($rose(rst_b_in) |-> !irq_out)
        else $error("interrupt high after reset");
    chk_base_copy: assert property (p_copy(6'h08, 6'h09, play_byte_in))
        else $error("playback base not copied");
    chk_cap_copy: assert property (p_copy(6'h0a, 6'h0b, cap_byte_in))
        else $error("capture base not copied");
endmodule
bind audio_dma_timer audio_dma_timer_chk i_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .byteenable_in(byteenable_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .play_byte_in(play_byte_in),
    .cap_byte_in(cap_byte_in), .irq_out(irq_out));
`default_nettype wire

// ### dv/dma_host_model.sv
// Behavioural system DMA controller giving one strobe per byte moved.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/100ps
`default_nettype none
module dma_host_model (
    // Clock
    input wire logic clk_in,
    // Byte strobes
    output logic play_byte_out,
    output logic cap_byte_out
);
    logic [1:0] strobe;
    assign play_byte_out = strobe[0];
    assign cap_byte_out = strobe[1];
    initial strobe = 2'b00;
    // Moves n bytes on channel ch with gap idle cycles between bytes.
    task automatic send(input int ch, input int n, input logic [1:0] gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            strobe[ch] <= 1'b1;
            if (gap != 2'h0) begin
                @(posedge clk_in);
                strobe[ch] <= 1'b0;
                repeat (gap - 1) @(posedge clk_in);
            end
        end
        @(posedge clk_in);
        strobe <= 2'b00;
        @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ### dv/test_audio_dma_timer.sv
// Self-checking bench for the audio DMA and timer counter block.
// Assumes the design, the host model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_audio_dma_timer;
    localparam int unsigned LONG = 50;
    logic clk_in;
    logic rst_b_in;
    logic [5:0] address_in;
    logic read_in;
    logic write_in;
    logic [3:0] byteenable_in;
    logic [31:0] writedata_in;
    logic [31:0] readdata_out;
    logic waitrequest_out;
    logic play_byte_in;
    logic cap_byte_in;
    logic irq_out;
    logic [15:0] seed;
    logic [15:0] b;
    logic [31:0] q;
    int err_count;
    int n_tests;
    audio_dma_timer #(.TB_LONG_CYCLES(LONG)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .address_in(address_in), .read_in(read_in), .write_in(write_in),
        .byteenable_in(byteenable_in), .writedata_in(writedata_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
        .play_byte_in(play_byte_in), .cap_byte_in(cap_byte_in), .irq_out(irq_out));
    dma_host_model i_host (.clk_in(clk_in), .play_byte_out(play_byte_in),
        .cap_byte_out(cap_byte_in));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] exp_cur(input logic [15:0] base, input int steps);
        logic [15:0] c;
        c = base;
        for (int i = 0; i < steps; i++) c = (c == 16'h0) ? base : c - 16'h1;
        return c;
    endfunction
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        address_in <= a;
        byteenable_in <= be;
        writedata_in <= d;
        write_in <= wr;
        read_in <= !wr;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (waitrequest_out !== 1'b0 && n < 20);
        q = readdata_out;
        read_in <= 1'b0;
        write_in <= 1'b0;
        if (n >= 20) begin
            err_count++;
            $display("unexpected at %0t: bus hang", $time);
            report_and_stop();
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, 4'h3, d);
    endtask
    task rd_chk(input logic [5:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 4'hf, 32'h0);
        check(q, exp, what);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        rst_b_in = 1'b0;
        address_in = 6'h00;
        read_in = 1'b0;
        write_in = 1'b0;
        byteenable_in = 4'h0;
        writedata_in = 32'h0;
        seed = 16'h42b6;
        err_count = 0;
        n_tests = 0;
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 8; i < 14; i++) rd_chk(6'(i), 32'h0, "reset count");
        bus(1'b1, 6'h01, 4'hf, 32'hffff_ffff);
        rd_chk(6'h01, 32'h0, "unmapped");
        bus(1'b1, 6'h00, 4'h1, 32'h0000_00ab);
        rd_chk(6'h00, 32'h0000_00ab, "low latch");
        bus(1'b1, 6'h08, 4'h2, 32'h0000_1200);
        rd_chk(6'h09, 32'h0000_12ab, "paired write");
        for (int ch = 0; ch < 2; ch++) begin
            seed = lfsr(seed);
            b = {13'h0, seed[2:0]} + 16'h1;
            wr(6'h10, 32'h0);
            wr(ch ? 6'h0a : 6'h08, {16'h0, b});
            rd_chk(ch ? 6'h0b : 6'h09, {16'h0, b}, "base copy");
            wr(6'h12, ch ? 32'h0 : 32'h1);
            wr(6'h10, 32'(1 << ch));
            i_host.send(ch, 4 * b, seed[4:3]);
            check({31'h0, irq_out}, 32'h0, "early irq");
            i_host.send(ch, 6, seed[6:5]);
            check({31'h0, irq_out}, {31'h0, ch == 0}, "masked irq");
            wr(6'h10, 32'h0);
            rd_chk(ch ? 6'h0b : 6'h09, {16'h0, exp_cur(b, b + 1)}, "reload");
            rd_chk(6'h11, 32'(1 << ch), "status");
            rd_chk(6'h11, 32'h0, "status clear");
            check({31'h0, irq_out}, 32'h0, "irq clear");
        end
        for (int sel = 0; sel < 2; sel++) begin
            b = sel ? 16'h2 : 16'h0;
            wr(6'h0c, {16'h0, b});
            rd_chk(6'h0d, {16'h0, b}, "timer copy");
            wr(6'h12, 32'h4);
            wr(6'h10, 32'h4 | 32'(sel << 3));
            repeat ((b + 1) * (sel ? LONG : 200) - 10) @(posedge clk_in);
            check({31'h0, irq_out}, 32'h0, "timer early");
            repeat (20) @(posedge clk_in);
            check({31'h0, irq_out}, 32'h1, "timer wrap");
            wr(6'h10, 32'h0);
            rd_chk(6'h0d, {16'h0, b}, "timer reload");
            rd_chk(6'h11, 32'h4, "timer status");
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
